// ==== common/scs_misc_pkg.sv ====
package scs_misc_pkg;
  // register byte offsets within this block's AHB window
  localparam logic [7:0] off_fp_context_address = 8'h00;
  localparam logic [7:0] off_fp_default_status_control = 8'h04;
  localparam logic [7:0] off_interrupt_controller_type = 8'h08;
  localparam logic [7:0] off_auxiliary_control = 8'h0C;
  localparam logic [7:0] off_software_interrupt_trigger = 8'h10;
  localparam logic [7:0] off_tick_control = 8'h14;
  localparam logic [7:0] off_tick_reload = 8'h18;
  localparam logic [7:0] off_tick_current = 8'h1C;
  localparam logic [7:0] off_irq_status = 8'h20;
  localparam logic [7:0] off_irq_clear = 8'h24;
  localparam logic [7:0] off_irq_enable = 8'h28;
  localparam logic [7:0] off_pending_base = 8'h40;
  localparam int pending_words = 16;

  localparam int fp_context_address_lsb = 3;
  localparam int ahp_bit = 26;
  localparam int dn_bit = 25;
  localparam int fz_bit = 24;
  localparam int rounding_mode_default_msb = 23;
  localparam int rounding_mode_default_lsb = 22;
  localparam int fp_default_status_control_w = 5;

  localparam int line_group_w = 4;
  localparam int trigger_w = 9;
  localparam int max_lines = 496;
  localparam int lines_per_group = 32;
  localparam int banked_lines = 32;

  localparam int tick_w = 24;
  localparam int tick_enable_bit = 0;
  localparam int tick_int_bit = 1;
  localparam int tick_clksrc_bit = 2;
  localparam int tick_flag_bit = 16;

  localparam int irq_wrap_bit = 0;
  localparam int irq_trigger_bit = 1;
  localparam int irq_ignored_bit = 2;
  localparam int irq_w = 3;

  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
  localparam logic [31:0] aux_reset = 32'h0000_0000;
endpackage : scs_misc_pkg

// ==== logic/pending_mem.sv ====
`timescale 1ns/1ps
// pending bits held as 16 words of 32; one set port, one word write port
module pending_mem
  import scs_misc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_en,
  input wire logic [trigger_w-1:0] set_idx,
  input wire logic wr_en,
  input wire logic [3:0] wr_word,
  input wire logic [31:0] wr_mask,
  input wire logic [3:0] rd_word,
  output logic [31:0] rd_data
);
  logic [31:0] mem_q [pending_words];

  genvar g;
  generate
    for (g = 0; g < pending_words; g++) begin : gen_word
      // software trigger is equivalent to a set-pending write
      wire logic hit_set = set_en && set_idx[trigger_w-1:5] == 4'(g);
      wire logic [31:0] set_bits = hit_set ? (32'h0000_0001 << set_idx[4:0]) : 32'h0000_0000;
      wire logic [31:0] wr_bits = (wr_en && wr_word == 4'(g)) ? wr_mask : 32'h0000_0000;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[g] <= 32'h0000_0000;
        end else begin
          mem_q[g] <= mem_q[g] | wr_bits | set_bits;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= mem_q[rd_word];
    end
  end
endmodule : pending_mem

// ==== logic/system_control_misc_regs.sv ====
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// Function
// - fp context address holds bits 31:3; bits 2:0 read zero, ignore writes
// - fp context and default status registers need privileged access
// - without fp extension those two locations are reserved
// - new fp context loads status control defaults from default register
// - default register holds bits 26, 25, 24 and 23:22; rest reserved
// - type register reports four-bit line group count in bits 3:0
// - at most 496 interrupts, count value 0b1111
// - first 32 interrupts banked per processor in multi-processor systems; here one shared pending store, not banked
// - line group count decides which pending registers exist
// - auxiliary control register always present, contents implementation defined
// - trigger write equals setting that interrupt's set-pending bit
// - trigger acts only on implemented external interrupts
// - 24-bit down-counter tick timer, cleared by writes, wraps at zero
// - tick control register exposes pollable count-reached flag
module system_control_misc_regs
  import scs_misc_pkg::*;
#(
  parameter bit fp_present = 1'b1,
  parameter logic [3:0] line_groups = 4'h1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fp_context_new,
  output logic [fp_default_status_control_w-1:0] fp_status_control_defaults,
  output logic [31:0] pending_rd_unused,
  output logic tick_pending,
  output logic irq
);
  // lines implemented, clipped to the architectural maximum
  localparam int raw_lines = lines_per_group * (int'(line_groups) + 1);
  localparam int num_lines = (raw_lines > max_lines) ? max_lines : raw_lines;

  // byte address bits of the window, and the word field inside them
  localparam int addr_w = 8;
  localparam int word_lsb = 2;
  localparam int pend_word_w = 4;

  // one entry per register location; everything unmapped folds onto sel_none
  typedef enum {
    sel_none,
    sel_fp_addr,
    sel_fp_dflt,
    sel_type,
    sel_aux,
    sel_trigger,
    sel_tick_ctl,
    sel_tick_reload,
    sel_tick_current,
    sel_irq_status,
    sel_irq_clear,
    sel_irq_enable,
    sel_pending
  } reg_sel_t;

  // data-phase kind remembered from the address phase
  typedef enum {
    ph_idle,
    ph_write,
    ph_read
  } bus_phase_t;

  function automatic logic fp_reg(input logic [7:0] a);
    return a == off_fp_context_address || a == off_fp_default_status_control;
  endfunction : fp_reg

  function automatic logic pend_reg(input logic [7:0] a);
    // only words covered by the implemented line groups decode
    return a >= off_pending_base && a[7:2] - off_pending_base[7:2] <= 6'(line_groups);
  endfunction : pend_reg

  // shared by the read mux (address phase) and the write strobes (data phase)
  function automatic reg_sel_t decode(input logic [addr_w-1:0] a);
    reg_sel_t s;
    case (a)
      off_fp_context_address: s = sel_fp_addr;
      off_fp_default_status_control: s = sel_fp_dflt;
      off_interrupt_controller_type: s = sel_type;
      off_auxiliary_control: s = sel_aux;
      off_software_interrupt_trigger: s = sel_trigger;
      off_tick_control: s = sel_tick_ctl;
      off_tick_reload: s = sel_tick_reload;
      off_tick_current: s = sel_tick_current;
      off_irq_status: s = sel_irq_status;
      off_irq_clear: s = sel_irq_clear;
      off_irq_enable: s = sel_irq_enable;
      default: s = pend_reg(a) ? sel_pending : sel_none;
    endcase
    return s;
  endfunction : decode

  bus_phase_t phase_q, phase_d;
  reg_sel_t dp_sel, ap_sel;
  logic wr_pend, rd_pend, priv_q;
  logic [addr_w-1:0] addr_q;
  logic [31:0] rd_mux;
  logic [31:0] fp_context_address_q;
  logic [fp_default_status_control_w-1:0] fp_default_status_control_q;
  logic [31:0] aux_q;
  logic [2:0] tick_ctl_q;
  logic tick_flag_q;
  logic [tick_w-1:0] reload_q, count_q;
  logic [irq_w-1:0] irq_status_q, irq_enable_q;
  logic [31:0] pend_rd;
  logic setp_en, bad_trig;
  logic [trigger_w-1:0] trig_idx;
  logic access_ok;
  logic wrap_evt, cur_wr, ctl_rd, pend_wr;

  wire logic addr_phase = hsel && hready && htrans == htrans_nonseq;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // non-word writes get no data phase at all, so they never reach a register
  always_comb begin
    phase_d = ph_idle;
    if (addr_phase && !hwrite) begin
      phase_d = ph_read;
    end else if (addr_phase && hsize == hsize_word) begin
      phase_d = ph_write;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= ph_idle;
      addr_q <= '0;
      priv_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      if (addr_phase) begin
        addr_q <= haddr[addr_w-1:0];
        priv_q <= hprot[1];
      end
    end
  end

  // read and write strobes of the data phase
  always_comb begin
    wr_pend = 1'b0;
    rd_pend = 1'b0;
    case (phase_q)
      ph_write: wr_pend = 1'b1;
      ph_read: rd_pend = 1'b1;
      ph_idle: wr_pend = 1'b0;
      default: wr_pend = 1'b0;
    endcase
  end

  assign dp_sel = decode(addr_q);
  assign ap_sel = decode(haddr[addr_w-1:0]);

  // unprivileged or absent fp accesses read zero and drop writes
  assign access_ok = !fp_reg(addr_q) || (priv_q && fp_present);
  wire logic do_wr = wr_pend && access_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fp_context_address_q <= 32'h0000_0000;
      fp_default_status_control_q <= '0;
    end else if (do_wr) begin
      if (dp_sel == sel_fp_addr) begin
        fp_context_address_q <= {hwdata[31:fp_context_address_lsb], 3'h0};
      end
      if (dp_sel == sel_fp_dflt) begin
        fp_default_status_control_q <= hwdata[ahp_bit:rounding_mode_default_lsb];
      end
    end
  end

  // defaults captured into the fp status control at each new context
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fp_status_control_defaults <= '0;
    end else if (fp_context_new && fp_present) begin
      fp_status_control_defaults <= fp_default_status_control_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_q <= aux_reset;
    end else if (do_wr && dp_sel == sel_aux) begin
      aux_q <= hwdata;
    end
  end

  // software trigger: index is exception number minus 16
  assign trig_idx = hwdata[trigger_w-1:0];
  wire logic trig_wr = do_wr && dp_sel == sel_trigger;
  assign bad_trig = trig_wr && 32'(trig_idx) >= num_lines;
  assign setp_en = trig_wr && !bad_trig;
  assign pend_wr = do_wr && dp_sel == sel_pending;

  // one pending store; the first 32 lines are not banked per core here
  pending_mem u_pending (
    .clk(hclk),
    .rst_n(hresetn),
    .set_en(setp_en),
    .set_idx(trig_idx),
    .wr_en(pend_wr),
    .wr_word(addr_q[word_lsb+pend_word_w-1:word_lsb]),
    .wr_mask(hwdata),
    .rd_word(haddr[word_lsb+pend_word_w-1:word_lsb]),
    .rd_data(pend_rd)
  );
  assign pending_rd_unused = pend_rd;

  // tick timer
  wire logic tick_run = tick_ctl_q[tick_enable_bit];
  wire logic tick_zero = count_q == '0;
  assign cur_wr = do_wr && dp_sel == sel_tick_current;
  assign ctl_rd = rd_pend && dp_sel == sel_tick_ctl;
  assign wrap_evt = tick_run && count_q == 24'(1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_ctl_q <= 3'h4;
      reload_q <= '0;
    end else if (do_wr) begin
      if (dp_sel == sel_tick_ctl) begin
        // processor clock only, so the source bit stays at one
        tick_ctl_q <= {1'b1, hwdata[tick_int_bit], hwdata[tick_enable_bit]};
      end
      if (dp_sel == sel_tick_reload) begin
        reload_q <= hwdata[tick_w-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (cur_wr) begin
      count_q <= '0;
    end else if (tick_run) begin
      // a reload of zero parks the counter at zero after its next wrap
      count_q <= tick_zero ? reload_q : count_q - 24'(1);
    end
  end

  // a transition to zero beats a same-cycle read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_flag_q <= 1'b0;
    end else if (wrap_evt) begin
      tick_flag_q <= 1'b1;
    end else if (ctl_rd || cur_wr) begin
      tick_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_pending <= 1'b0;
    end else begin
      tick_pending <= wrap_evt && tick_ctl_q[tick_int_bit];
    end
  end

  // sticky event status, set wins over clear
  wire logic [irq_w-1:0] evts = {bad_trig, setp_en, wrap_evt};
  wire logic [irq_w-1:0] clr = (do_wr && dp_sel == sel_irq_clear) ? hwdata[irq_w-1:0] : '0;
  wire logic [irq_w-1:0] status_d;

  // one bit per event source; a clear in the cycle of a new event leaves it set
  for (genvar b = 0; b < irq_w; b++) begin : gen_status
    assign status_d[b] = evts[b] || (irq_status_q[b] && !clr[b]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= status_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_q <= '0;
    end else if (do_wr && dp_sel == sel_irq_enable) begin
      irq_enable_q <= hwdata[irq_w-1:0];
    end
  end

  // built from the next status so the line rises together with the status bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & irq_enable_q);
    end
  end

  // read data chosen in the address phase so the data phase sees a flop output
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ap_sel)
      sel_fp_addr: begin
        if (hprot[1] && fp_present) begin
          rd_mux = fp_context_address_q;
        end
      end
      sel_fp_dflt: begin
        if (hprot[1] && fp_present) begin
          rd_mux[ahp_bit:rounding_mode_default_lsb] = fp_default_status_control_q;
        end
      end
      sel_type: rd_mux[line_group_w-1:0] = line_groups;
      sel_aux: rd_mux = aux_q;
      sel_tick_ctl: begin
        rd_mux[tick_clksrc_bit:0] = tick_ctl_q;
        rd_mux[tick_flag_bit] = tick_flag_q;
      end
      sel_tick_reload: rd_mux[tick_w-1:0] = reload_q;
      sel_tick_current: rd_mux[tick_w-1:0] = count_q;
      sel_irq_status: rd_mux[irq_w-1:0] = irq_status_q;
      sel_irq_enable: rd_mux[irq_w-1:0] = irq_enable_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (phase_d == ph_read) begin
      hrdata <= rd_mux;
    end
  end
endmodule : system_control_misc_regs

// ==== verification/scs_misc_properties.sv ====
`timescale 1ns/1ps
module scs_misc_checker
  import scs_misc_pkg::*;
#(
  parameter logic [3:0] line_groups = 4'h1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [3:0] hprot,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic fp_context_new,
  input wire logic [fp_default_status_control_w-1:0] fp_status_control_defaults,
  input wire logic tick_pending,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd = hsel && hready && htrans == htrans_nonseq && !hwrite;
  a_zero_wait: assert property (hreadyout) else $error("slave stalled");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_fp_context_address_low: assert property (
    rd && haddr[7:0] == off_fp_context_address |=> hrdata[2:0] == 3'h0)
    else $error("context address low bits set");
  a_user_blank: assert property (
    rd && !hprot[1] && haddr[7:0] <= off_fp_default_status_control |=> hrdata == 32'h0)
    else $error("unprivileged fp read not blank");
  a_dscr_reserved: assert property (
    rd && haddr[7:0] == off_fp_default_status_control
    |=> hrdata[31:27] == 5'h0 && hrdata[21:0] == 22'h0)
    else $error("reserved default bits set");
  a_type_count: assert property (
    rd && haddr[7:0] == off_interrupt_controller_type |=> hrdata == {28'h0, line_groups})
    else $error("line group count wrong");
  a_defaults_hold: assert property (
    !fp_context_new |=> $stable(fp_status_control_defaults))
    else $error("defaults moved without new context");
  a_tick_pulse: assert property (tick_pending |=> !tick_pending)
    else $error("tick pulse too long");
  c_new_ctx: cover property (fp_context_new);
  c_tick: cover property (tick_pending);
  c_irq: cover property ($rose(irq));
endmodule : scs_misc_checker

bind system_control_misc_regs scs_misc_checker #(.line_groups(line_groups)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hprot(hprot), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .fp_context_new(fp_context_new),
  .fp_status_control_defaults(fp_status_control_defaults),
  .tick_pending(tick_pending), .irq(irq));

// ==== verification/system_control_misc_regs_tb.sv ====
`timescale 1ns/1ps
module system_control_misc_regs_tb;
  import scs_misc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic fp_new = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [3:0] hprot = 4'h3;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] seed = 32'h2728;
  logic hreadyout, hresp, tick_pending, irq;
  logic [31:0] hrdata, pend_seen, rd, v, fp_context_address_m, dscr_m, stat_m;
  logic [fp_default_status_control_w-1:0] defs;
  logic [63:0] pend_m = 64'h0;
  logic [8:0] idx;
  int n_fail = 0;
  int compares = 0;
  int t;
  always #4 hclk = ~hclk;
  system_control_misc_regs i_system_control_misc_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize_word), .hprot(hprot), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fp_context_new(fp_new), .fp_status_control_defaults(defs),
    .pending_rd_unused(pend_seen), .tick_pending(tick_pending), .irq(irq));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // waits for an edge with hready high; the bound stands in for a hung slave
  task automatic edge_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_fail++;
        tally_and_finish();
      end
      @(posedge hclk);
    end
  endtask : edge_rdy
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic p);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= htrans_nonseq;
    hwrite <= w;
    hprot <= {2'h0, p, 1'b1};
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask : xfer
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(off_interrupt_controller_type, 1'b0, 32'h0, 1'b1);
    chk("type", 32'h1, rd);
    xfer(off_auxiliary_control, 1'b0, 32'h0, 1'b1);
    chk("aux", aux_reset, rd);
    xfer(8'h30, 1'b0, 32'h0, 1'b1);
    chk("unmapped", 32'h0, rd);
    v = rnd();
    fp_context_address_m = v & 32'hFFFF_FFF8;
    xfer(off_fp_context_address, 1'b1, v, 1'b1);
    xfer(off_fp_context_address, 1'b1, ~v, 1'b0);
    xfer(off_fp_context_address, 1'b0, 32'h0, 1'b0);
    chk("fp_context_address_user", 32'h0, rd);
    xfer(off_fp_context_address, 1'b0, 32'h0, 1'b1);
    chk("fp_context_address", fp_context_address_m, rd);
    v = rnd();
    dscr_m = v & 32'h07C0_0000;
    xfer(off_fp_default_status_control, 1'b1, v, 1'b1);
    xfer(off_fp_default_status_control, 1'b0, 32'h0, 1'b1);
    chk("fp_default_status_control", dscr_m, rd);
    fp_new <= 1'b1;
    @(posedge hclk);
    fp_new <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("defaults", {27'h0, dscr_m[26:22]}, {27'h0, defs});
    $display("test fp done");
    stat_m = 32'h0;
    // 63 and 64 straddle the last implemented line; odd passes reach far beyond
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      idx = (k == 0) ? 9'd63 : (k == 1) ? 9'd64 : v[8:0] & (k[0] ? 9'h1FF : 9'h03F);
      xfer(off_software_interrupt_trigger, 1'b1, {23'h0, idx}, 1'b1);
      if (idx < 9'd64) begin
        pend_m[idx[5:0]] = 1'b1;
        stat_m[irq_trigger_bit] = 1'b1;
      end else begin
        stat_m[irq_ignored_bit] = 1'b1;
      end
      haddr <= {24'h0, off_pending_base + (idx[5] ? 8'h04 : 8'h00)};
      repeat (3) @(posedge hclk);
      chk("pending", idx[5] ? pend_m[63:32] : pend_m[31:0], pend_seen);
    end
    v = rnd();
    xfer(off_pending_base + 8'h04, 1'b1, v, 1'b1);
    xfer(off_pending_base + 8'h08, 1'b1, v, 1'b1);
    pend_m[63:32] = pend_m[63:32] | v;
    haddr <= {24'h0, off_pending_base + 8'h04};
    repeat (3) @(posedge hclk);
    chk("pending_wr", pend_m[63:32], pend_seen);
    haddr <= {24'h0, off_pending_base + 8'h08};
    repeat (3) @(posedge hclk);
    chk("pending_absent", 32'h0, pend_seen);
    xfer(off_irq_status, 1'b0, 32'h0, 1'b1);
    chk("status", stat_m, rd);
    xfer(off_irq_enable, 1'b1, 32'h6, 1'b1);
    repeat (2) @(posedge hclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    xfer(off_irq_enable, 1'b1, 32'h0, 1'b1);
    repeat (2) @(posedge hclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    xfer(off_irq_clear, 1'b1, 32'h7, 1'b1);
    xfer(off_irq_status, 1'b0, 32'h0, 1'b1);
    chk("status_clr", 32'h0, rd);
    $display("test trigger done");
    xfer(off_irq_enable, 1'b1, 32'h1, 1'b1);
    xfer(off_tick_reload, 1'b1, 32'h5, 1'b1);
    xfer(off_tick_current, 1'b1, rnd(), 1'b1);
    xfer(off_tick_control, 1'b1, 32'h3, 1'b1);
    t = 0;
    while (tick_pending !== 1'b1 && t < 40) begin
      @(posedge hclk);
      t++;
    end
    chk("tick_seen", 32'h1, {31'h0, tick_pending});
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (tick_pending !== 1'b1 && t < 40);
    chk("tick_period", 32'd6, t);
    xfer(off_tick_control, 1'b1, 32'h0, 1'b1);
    xfer(off_tick_control, 0, 32'h0, 1'b1);
    chk("flag_set", 32'h0001_0004, rd);
    xfer(off_tick_control, 0, 32'h0, 1'b1);
    chk("flag_clear", 32'h0000_0004, rd);
    xfer(off_irq_status, 1'b0, 32'h0, 1'b1);
    chk("tick_status", 32'h1, rd);
    chk("irq_tick", 32'h1, {31'h0, irq});
    $display("test tick done");
    tally_and_finish();
  end
endmodule : system_control_misc_regs_tb
